// ===== rtl/sense_mux_cfg.svh
// Register offsets, field positions, reset values and codes of the sense output pin multiplexer.
// Assumes inclusion by bare name from the design modules and the bench.
`ifndef SENSE_MUX_CFG_SVH
`define SENSE_MUX_CFG_SVH

`define SM_ADDR_W          10
`define SM_DATA_W          16

`define SM_OFS_OUT_CFG     10'h01AA
`define SM_OFS_FLAG_DIR    10'h01C1
`define SM_OFS_FLAG_ROUTE  10'h01C3

`define SM_RST_WORD        16'h0000
`define SM_CFG_MASK        16'h007F
`define SM_FLAG_MASK       16'h0C00

`define SM_SEL_LSB         0
`define SM_SEL_MSB         2
`define SM_GAIN_LSB        3
`define SM_GAIN_MSB        4
`define SM_EN_BIT          5
`define SM_PSEL_BIT        6

`define SM_FLAG_A_BIT      10
`define SM_FLAG_B_BIT      11

`define SM_SRC_FIRST       3'h0
`define SM_SRC_SECOND      3'h1
`define SM_SRC_REF         3'h5

`define SM_GAIN_C0         10'h085
`define SM_GAIN_C1         10'h0C8
`define SM_GAIN_C2         10'h12C
`define SM_GAIN_C3         10'h215

`define SM_CH_NONE         3'h0
`define SM_CH_1            3'h1
`define SM_CH_2            3'h2
`define SM_CH_3            3'h3
`define SM_CH_4            3'h4

`endif

// ===== rtl/sense_mux_pkg.sv
// Types shared by the sense output pin multiplexer modules.
// Assumes the configuration header sits on the include path.
`default_nettype none
package sense_mux_pkg;

   typedef enum logic [1:0] {
      SRC_OFF,
      SRC_FIRST,
      SRC_SECOND,
      SRC_REF
   } src_t;

   typedef enum logic [1:0] {
      MODE_ANALOG,
      MODE_DIG_OUT,
      MODE_DIG_IN,
      MODE_PARKED
   } pin_mode_t;

   typedef struct packed {
      logic      oe;
      logic      dout;
      pin_mode_t mode;
      src_t      src;
      logic [2:0] channel;
      logic [1:0] gain_code;
      logic [9:0] gain_x100;
      logic       bias_shift;
   } lane_out_t;

endpackage
`default_nettype wire

// ===== rtl/sense_mux_lane.sv
// One output pin lane: decodes its configuration into registered pin controls.
// Assumes configuration words already masked and synchronous to i_ref_clk.
`include "sense_mux_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module sense_mux_lane
#(
   parameter logic [2:0] FIRST_CH  = `SM_CH_1,
   parameter logic [2:0] SECOND_CH = `SM_CH_3
)
(
   // Clock and reset.
   input  wire logic                   i_ref_clk,
   input  wire logic                   i_resetn,
   // Configuration.
   input  wire logic [15:0]            i_cfg,
   input  wire logic                   i_route,
   input  wire logic                   i_dir,
   input  wire logic                   i_flag_drive,
   // Decoded lane.
   output var  sense_mux_pkg::lane_out_t o_lane
);

   if (FIRST_CH == `SM_CH_NONE || SECOND_CH == `SM_CH_NONE || FIRST_CH == SECOND_CH)
   begin : g_bad_channels
      $error("sense_mux_lane: channel numbers must be distinct and nonzero");
   end

   sense_mux_pkg::lane_out_t lane_d;
   logic [2:0]               sel;
   logic [1:0]               gain;
   logic                     en;
   logic                     psel;

   always_comb
   begin
      sel  = i_cfg[`SM_SEL_MSB:`SM_SEL_LSB];
      gain = i_cfg[`SM_GAIN_MSB:`SM_GAIN_LSB];
      en   = i_cfg[`SM_EN_BIT];
      psel = i_cfg[`SM_PSEL_BIT];
      lane_d            = '0;
      lane_d.gain_code  = gain;
      lane_d.bias_shift = gain[1];
      unique case (gain)
         2'b00: lane_d.gain_x100 = `SM_GAIN_C0;
         2'b01: lane_d.gain_x100 = `SM_GAIN_C1;
         2'b10: lane_d.gain_x100 = `SM_GAIN_C2;
         2'b11: lane_d.gain_x100 = `SM_GAIN_C3;
      endcase
      if (i_route && i_dir)
         lane_d.mode = sense_mux_pkg::MODE_DIG_IN;
      else if (i_route && psel)
         lane_d.mode = sense_mux_pkg::MODE_DIG_OUT;
      else if (!i_route && !psel)
         lane_d.mode = sense_mux_pkg::MODE_ANALOG;
      else
         lane_d.mode = sense_mux_pkg::MODE_PARKED;
      unique case (lane_d.mode)
         sense_mux_pkg::MODE_ANALOG:
         begin
            lane_d.oe = en;
            if (en)
            begin
               if (sel == `SM_SRC_FIRST)
               begin
                  lane_d.src     = sense_mux_pkg::SRC_FIRST;
                  lane_d.channel = FIRST_CH;
               end
               else if (sel == `SM_SRC_SECOND)
               begin
                  lane_d.src     = sense_mux_pkg::SRC_SECOND;
                  lane_d.channel = SECOND_CH;
               end
               else if (sel == `SM_SRC_REF)
                  lane_d.src = sense_mux_pkg::SRC_REF;
            end
         end
         sense_mux_pkg::MODE_DIG_OUT:
         begin
            lane_d.oe   = 1'b1;
            lane_d.dout = i_flag_drive;
         end
         sense_mux_pkg::MODE_DIG_IN,
         sense_mux_pkg::MODE_PARKED:
         begin
            lane_d.oe   = 1'b0;
            lane_d.dout = 1'b0;
         end
      endcase
   end

   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         o_lane <= '0;
      else
         o_lane <= lane_d;
   end

endmodule
`default_nettype wire

// ===== rtl/sense_output_pin_mux.sv
// Top of the sense output pin multiplexer: configuration registers, microcore writes and two pin lanes.
// Assumes the register port and microcore port are synchronous to i_ref_clk and the pins are sampled as such.
`include "sense_mux_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module sense_output_pin_mux
(
   // Clock and reset.
   input  wire logic                     i_ref_clk,
   input  wire logic                     i_resetn,
   // Register port.
   input  wire logic                     i_reg_wr,
   input  wire logic                     i_reg_rd,
   input  wire logic [`SM_ADDR_W-1:0]    i_reg_addr,
   input  wire logic                     i_reg_page,
   input  wire logic [`SM_DATA_W-1:0]    i_reg_wdata,
   output logic      [`SM_DATA_W-1:0]    o_reg_rdata,
   // Microcore configuration port.
   input  wire logic                     i_core_wr,
   input  wire logic                     i_core_pin,
   input  wire logic [`SM_DATA_W-1:0]    i_core_cfg,
   // Flag bus.
   input  wire logic [1:0]               i_flag_drive_signal,
   output logic      [1:0]               o_flag_in,
   // Pin A.
   input  wire logic                     i_sense_out_pin_a_in,
   output logic                          o_sense_out_pin_a_out,
   output logic                          o_sense_out_pin_a_oe,
   output var  sense_mux_pkg::lane_out_t o_pin_a_lane,
   // Pin B.
   input  wire logic                     i_sense_out_pin_b_in,
   output logic                          o_sense_out_pin_b_out,
   output logic                          o_sense_out_pin_b_oe,
   output var  sense_mux_pkg::lane_out_t o_pin_b_lane
);

   logic [`SM_DATA_W-1:0] cfg_q [2];
   logic [`SM_DATA_W-1:0] flag_dir_q;
   logic [`SM_DATA_W-1:0] flag_route_q;
   logic [`SM_DATA_W-1:0] rdata_d;
   logic [1:0]            route_bits;
   logic [1:0]            dir_bits;
   logic [1:0]            pin_in;
   logic [1:0]            flag_in_q;
   sense_mux_pkg::lane_out_t lanes [2];

   function automatic logic [2:0] cfg_sel(input logic [`SM_DATA_W-1:0] w);
      cfg_sel = w[`SM_SEL_MSB:`SM_SEL_LSB];
   endfunction

   function automatic logic cfg_analog_on(input logic [`SM_DATA_W-1:0] w, input logic route);
      cfg_analog_on = !route && !w[`SM_PSEL_BIT] && w[`SM_EN_BIT];
   endfunction

   function automatic logic reg_hit(input logic [`SM_ADDR_W-1:0] a, input logic [`SM_ADDR_W-1:0] ofs);
      reg_hit = (a == ofs);
   endfunction

   // Gain in hundredths that each gain code must give.
   function automatic logic [9:0] exp_gain(input logic [1:0] code);
      case (code)
         2'b00:   exp_gain = `SM_GAIN_C0;
         2'b01:   exp_gain = `SM_GAIN_C1;
         2'b10:   exp_gain = `SM_GAIN_C2;
         default: exp_gain = `SM_GAIN_C3;
      endcase
   endfunction

   // Pin configuration registers, written by the register port or a microcore; the core wins a tie.
   generate
      for (genvar p = 0; p < 2; p++)
      begin : g_cfg
         always_ff @(posedge i_ref_clk or negedge i_resetn)
         begin
            if (!i_resetn)
               cfg_q[p] <= `SM_RST_WORD;
            else if (i_core_wr && (i_core_pin == 1'(p)))
               cfg_q[p] <= i_core_cfg & `SM_CFG_MASK;
            else if (i_reg_wr && reg_hit(i_reg_addr, `SM_OFS_OUT_CFG) && (i_reg_page == 1'(p)))
               cfg_q[p] <= i_reg_wdata & `SM_CFG_MASK;
         end
      end
   endgenerate

   // Flag direction register; only the two pin lines are implemented.
   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         flag_dir_q <= `SM_RST_WORD;
      else if (i_reg_wr && reg_hit(i_reg_addr, `SM_OFS_FLAG_DIR))
         flag_dir_q <= i_reg_wdata & `SM_FLAG_MASK;
   end

   // Flag routing register; only the two pin lines are implemented.
   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         flag_route_q <= `SM_RST_WORD;
      else if (i_reg_wr && reg_hit(i_reg_addr, `SM_OFS_FLAG_ROUTE))
         flag_route_q <= i_reg_wdata & `SM_FLAG_MASK;
   end

   assign route_bits = {flag_route_q[`SM_FLAG_B_BIT], flag_route_q[`SM_FLAG_A_BIT]};
   assign dir_bits   = {flag_dir_q[`SM_FLAG_B_BIT], flag_dir_q[`SM_FLAG_A_BIT]};
   assign pin_in     = {i_sense_out_pin_b_in, i_sense_out_pin_a_in};

   // Read data; unmapped addresses read as zero.
   always_comb
   begin
      rdata_d = '0;
      if (reg_hit(i_reg_addr, `SM_OFS_OUT_CFG))
         rdata_d = i_reg_page ? cfg_q[1] : cfg_q[0];
      else if (reg_hit(i_reg_addr, `SM_OFS_FLAG_DIR))
         rdata_d = flag_dir_q;
      else if (reg_hit(i_reg_addr, `SM_OFS_FLAG_ROUTE))
         rdata_d = flag_route_q;
   end

   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         o_reg_rdata <= '0;
      else if (i_reg_rd)
         o_reg_rdata <= rdata_d;
   end

   // Pin lanes; each lane carries only its own pair of current channels.
   generate
      for (genvar p = 0; p < 2; p++)
      begin : g_lane
         localparam logic [2:0] FIRST  = (p == 0) ? `SM_CH_1 : `SM_CH_2;
         localparam logic [2:0] SECOND = (p == 0) ? `SM_CH_3 : `SM_CH_4;
         sense_mux_lane
         #(
            .FIRST_CH  (FIRST),
            .SECOND_CH (SECOND)
         )
         u_lane
         (
            .i_ref_clk    (i_ref_clk),
            .i_resetn     (i_resetn),
            .i_cfg        (cfg_q[p]),
            .i_route      (route_bits[p]),
            .i_dir        (dir_bits[p]),
            .i_flag_drive (i_flag_drive_signal[p]),
            .o_lane       (lanes[p])
         );

         // A pin in digital input mode passes its level onto its flag line.
         always_ff @(posedge i_ref_clk or negedge i_resetn)
         begin
            if (!i_resetn)
               flag_in_q[p] <= 1'b0;
            else
               flag_in_q[p] <= (lanes[p].mode == sense_mux_pkg::MODE_DIG_IN) && pin_in[p];
         end
      end
   endgenerate

   assign o_pin_a_lane          = lanes[0];
   assign o_pin_b_lane          = lanes[1];
   assign o_sense_out_pin_a_out = lanes[0].dout;
   assign o_sense_out_pin_a_oe  = lanes[0].oe;
   assign o_sense_out_pin_b_out = lanes[1].dout;
   assign o_sense_out_pin_b_oe  = lanes[1].oe;
   assign o_flag_in             = flag_in_q;

   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_resetn);

   chk_gain_map_a: assert property (
      1'b1 |=> o_pin_a_lane.gain_x100 ==
         exp_gain($past(cfg_q[0][`SM_GAIN_MSB:`SM_GAIN_LSB])))
      else $error("pin A gain does not match its gain code");

   chk_bias_shift_b: assert property (
      o_pin_b_lane.bias_shift == (o_pin_b_lane.gain_x100 > `SM_GAIN_C1))
      else $error("pin B bias shift disagrees with the gain");

   chk_pin_a_source: assert property (
      cfg_analog_on(cfg_q[0], route_bits[0]) && cfg_sel(cfg_q[0]) == `SM_SRC_SECOND
      |=> o_pin_a_lane.channel == `SM_CH_3 && o_pin_a_lane.src == sense_mux_pkg::SRC_SECOND)
      else $error("pin A select 001 did not route channel 3");

   chk_pin_b_source: assert property (
      cfg_analog_on(cfg_q[1], route_bits[1]) && cfg_sel(cfg_q[1]) == `SM_SRC_FIRST
      |=> o_pin_b_lane.channel == `SM_CH_2 && o_sense_out_pin_b_oe)
      else $error("pin B select 000 did not route channel 2");

   chk_pin_b_reference: assert property (
      cfg_analog_on(cfg_q[1], route_bits[1]) && cfg_sel(cfg_q[1]) == `SM_SRC_REF
      |=> o_pin_b_lane.src == sense_mux_pkg::SRC_REF && o_pin_b_lane.channel == `SM_CH_NONE)
      else $error("pin B select 101 did not route the reference");

   chk_enable_off_hiz: assert property (
      !route_bits[0] && !cfg_q[0][`SM_PSEL_BIT] && !cfg_q[0][`SM_EN_BIT]
      |=> !o_sense_out_pin_a_oe && o_pin_a_lane.src == sense_mux_pkg::SRC_OFF)
      else $error("pin A drives while its enable is low");

   chk_channel_split: assert property (
      (o_pin_a_lane.channel inside {`SM_CH_NONE, `SM_CH_1, `SM_CH_3}) &&
      (o_pin_b_lane.channel inside {`SM_CH_NONE, `SM_CH_2, `SM_CH_4}))
      else $error("a current channel reached the wrong pin");

   chk_core_write: assert property (
      i_core_wr && !i_core_pin |=> cfg_q[0] == ($past(i_core_cfg) & `SM_CFG_MASK))
      else $error("microcore write to pin A configuration was lost");

   chk_spi_cfg_write: assert property (
      i_reg_wr && i_reg_addr == `SM_OFS_OUT_CFG && i_reg_page && !(i_core_wr && i_core_pin)
      |=> cfg_q[1] == ($past(i_reg_wdata) & `SM_CFG_MASK))
      else $error("register write to pin B configuration was lost");

   chk_digital_in_hiz: assert property (
      route_bits[1] && dir_bits[1] |=> !o_sense_out_pin_b_oe && !o_sense_out_pin_b_out)
      else $error("pin B drives while configured as a digital input");

   chk_digital_out_drive: assert property (
      route_bits[0] && !dir_bits[0] && cfg_q[0][`SM_PSEL_BIT]
      |=> o_sense_out_pin_a_oe && o_sense_out_pin_a_out == $past(i_flag_drive_signal[0]))
      else $error("pin A digital output does not follow its flag value");

   chk_analog_follows_en: assert property (
      !route_bits[1] && !cfg_q[1][`SM_PSEL_BIT] ##1 $stable(cfg_q[1]) && $stable(route_bits)
      |=> o_sense_out_pin_b_oe == $past(cfg_q[1][`SM_EN_BIT]) && !o_sense_out_pin_b_out)
      else $error("pin B analog buffer does not follow its enable");

   chk_flag_in_path: assert property (
      o_pin_a_lane.mode == sense_mux_pkg::MODE_DIG_IN && i_sense_out_pin_a_in |=> o_flag_in[0])
      else $error("pin A input level did not reach flag line 10");

   chk_reserved_none: assert property (
      cfg_analog_on(cfg_q[0], route_bits[0]) &&
      !(cfg_sel(cfg_q[0]) inside {`SM_SRC_FIRST, `SM_SRC_SECOND, `SM_SRC_REF})
      |=> o_pin_a_lane.src == sense_mux_pkg::SRC_OFF && o_pin_a_lane.oe)
      else $error("reserved select on pin A routed a source");

   chk_gain_map_b: assert property (
      1'b1 |=> o_pin_b_lane.gain_x100 ==
         exp_gain($past(cfg_q[1][`SM_GAIN_MSB:`SM_GAIN_LSB])))
      else $error("pin B gain does not match its gain code");

   chk_bias_shift_a: assert property (
      1'b1 |=> o_pin_a_lane.bias_shift == $past(cfg_q[0][`SM_GAIN_MSB]))
      else $error("pin A bias shift disagrees with its gain code");

   chk_pin_a_first: assert property (
      cfg_analog_on(cfg_q[0], route_bits[0]) && cfg_sel(cfg_q[0]) == `SM_SRC_FIRST
      |=> o_pin_a_lane.channel == `SM_CH_1 && o_sense_out_pin_a_oe)
      else $error("pin A select 000 did not route channel 1");

   chk_pin_a_reference: assert property (
      cfg_analog_on(cfg_q[0], route_bits[0]) && cfg_sel(cfg_q[0]) == `SM_SRC_REF
      |=> o_pin_a_lane.src == sense_mux_pkg::SRC_REF && o_pin_a_lane.channel == `SM_CH_NONE)
      else $error("pin A select 101 did not route the reference");

   chk_pin_b_second: assert property (
      cfg_analog_on(cfg_q[1], route_bits[1]) && cfg_sel(cfg_q[1]) == `SM_SRC_SECOND
      |=> o_pin_b_lane.channel == `SM_CH_4 && o_pin_b_lane.src == sense_mux_pkg::SRC_SECOND)
      else $error("pin B select 001 did not route channel 4");

   chk_enable_off_hiz_b: assert property (
      !route_bits[1] && !cfg_q[1][`SM_PSEL_BIT] && !cfg_q[1][`SM_EN_BIT]
      |=> !o_sense_out_pin_b_oe && o_pin_b_lane.src == sense_mux_pkg::SRC_OFF)
      else $error("pin B drives while its enable is low");

   chk_digital_in_hiz_a: assert property (
      route_bits[0] && dir_bits[0]
      |=> !o_sense_out_pin_a_oe && !o_sense_out_pin_a_out)
      else $error("pin A drives while configured as a digital input");

   chk_digital_out_b: assert property (
      route_bits[1] && !dir_bits[1] && cfg_q[1][`SM_PSEL_BIT]
      |=> o_sense_out_pin_b_oe && o_sense_out_pin_b_out == $past(i_flag_drive_signal[1]))
      else $error("pin B digital output does not follow its flag value");

   chk_parked_quiet: assert property (
      route_bits[0] != cfg_q[0][`SM_PSEL_BIT] && !dir_bits[0]
      |=> !o_sense_out_pin_a_oe && !o_sense_out_pin_a_out)
      else $error("pin A drives while routing and function select disagree");

   chk_flag_in_path_b: assert property (
      o_pin_b_lane.mode == sense_mux_pkg::MODE_DIG_IN && i_sense_out_pin_b_in
      |=> o_flag_in[1])
      else $error("pin B input level did not reach flag line 11");

   chk_flag_in_quiet: assert property (
      o_pin_a_lane.mode != sense_mux_pkg::MODE_DIG_IN |=> !o_flag_in[0])
      else $error("flag line 10 set while pin A is not a digital input");

   chk_core_write_b: assert property (
      i_core_wr && i_core_pin
      |=> cfg_q[1] == ($past(i_core_cfg) & `SM_CFG_MASK))
      else $error("microcore write to pin B configuration was lost");

   chk_spi_cfg_write_a: assert property (
      i_reg_wr && i_reg_addr == `SM_OFS_OUT_CFG && !i_reg_page && !(i_core_wr && !i_core_pin)
      |=> cfg_q[0] == ($past(i_reg_wdata) & `SM_CFG_MASK))
      else $error("register write to pin A configuration was lost");

   chk_cfg_readback: assert property (
      i_reg_rd && i_reg_addr == `SM_OFS_OUT_CFG && i_reg_page
      |=> o_reg_rdata == $past(cfg_q[1]))
      else $error("pin B configuration did not read back");

   chk_route_write: assert property (
      i_reg_wr && i_reg_addr == `SM_OFS_FLAG_ROUTE
      |=> flag_route_q == ($past(i_reg_wdata) & `SM_FLAG_MASK))
      else $error("flag routing write was lost");

   chk_dir_write: assert property (
      i_reg_wr && i_reg_addr == `SM_OFS_FLAG_DIR
      |=> flag_dir_q == ($past(i_reg_wdata) & `SM_FLAG_MASK))
      else $error("flag direction write was lost");

   cov_share_adc: cover property (
      o_sense_out_pin_a_oe && !o_sense_out_pin_b_oe ##[1:20] !o_sense_out_pin_a_oe && o_sense_out_pin_b_oe);

   cov_reference_check: cover property (
      o_pin_a_lane.src == sense_mux_pkg::SRC_REF);

   cov_digital_out: cover property (
      o_pin_b_lane.mode == sense_mux_pkg::MODE_DIG_OUT && o_sense_out_pin_b_out);

   cov_core_over_spi: cover property (
      i_core_wr && i_reg_wr && i_reg_addr == `SM_OFS_OUT_CFG && (i_reg_page == i_core_pin));

endmodule
`default_nettype wire

// ===== bench/flag_host_model.sv
// Host side of one sense output pin: an ADC input or flag bus line, plus the pad's weak pull-down.
// Assumes the device drives the pad only while its output enable is high.
`timescale 1ns/1ps
`default_nettype none
module flag_host_model
(
   // Device side of the pad.
   input  wire logic i_dev_oe,
   input  wire logic i_dev_out,
   // Host drive of the flag line.
   input  wire logic i_host_oe,
   input  wire logic i_host_val,
   // Resolved pad level.
   output logic      o_pad
);
   // With nobody driving, the pull-down settles the pad low.
   assign o_pad = i_dev_oe ? i_dev_out : (i_host_oe ? i_host_val : 1'b0);
endmodule
`default_nettype wire

// ===== bench/tb.sv
// Self-checking bench of the sense output pin multiplexer, with a host model on each pin.
// Assumes the configuration header is on the include path.
`include "sense_mux_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic                     i_ref_clk = 1'b0;
   logic                     i_resetn = 1'b0;
   logic                     i_reg_wr = 1'b0;
   logic                     i_reg_rd = 1'b0;
   logic [9:0]               i_reg_addr = 10'h000;
   logic                     i_reg_page = 1'b0;
   logic [15:0]              i_reg_wdata = 16'h0000;
   logic [15:0]              o_reg_rdata;
   logic                     i_core_wr = 1'b0;
   logic                     i_core_pin = 1'b0;
   logic [15:0]              i_core_cfg = 16'h0000;
   logic [1:0]               i_flag_drive_signal = 2'b00;
   logic [1:0]               o_flag_in;
   wire logic [1:0]          pad;
   wire logic [1:0]          pin_out;
   wire logic [1:0]          pin_oe;
   logic [1:0]               host_oe = 2'b00;
   logic [1:0]               host_val = 2'b00;
   sense_mux_pkg::lane_out_t o_pin_a_lane;
   sense_mux_pkg::lane_out_t o_pin_b_lane;
   int                       failures = 0;
   int                       num_checks = 0;
   logic [6:0]               cfg;

   initial
   begin
      forever #50 i_ref_clk = ~i_ref_clk;
   end

   sense_output_pin_mux i_sense_output_pin_mux (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
      .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_page(i_reg_page),
      .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .i_core_wr(i_core_wr), .i_core_pin(i_core_pin),
      .i_core_cfg(i_core_cfg), .i_flag_drive_signal(i_flag_drive_signal), .o_flag_in(o_flag_in),
      .i_sense_out_pin_a_in(pad[0]), .o_sense_out_pin_a_out(pin_out[0]), .o_sense_out_pin_a_oe(pin_oe[0]),
      .o_pin_a_lane(o_pin_a_lane), .i_sense_out_pin_b_in(pad[1]), .o_sense_out_pin_b_out(pin_out[1]),
      .o_sense_out_pin_b_oe(pin_oe[1]), .o_pin_b_lane(o_pin_b_lane));

   flag_host_model i_flag_host_model_a (.i_dev_oe(pin_oe[0]), .i_dev_out(pin_out[0]),
      .i_host_oe(host_oe[0]), .i_host_val(host_val[0]), .o_pad(pad[0]));
   flag_host_model i_flag_host_model_b (.i_dev_oe(pin_oe[1]), .i_dev_out(pin_out[1]),
      .i_host_oe(host_oe[1]), .i_host_val(host_val[1]), .o_pad(pad[1]));

   task automatic conclude();
      $display("Checks made: %0d, mismatches: %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic reg_wr(input logic [9:0] addr, input logic page, input logic [15:0] data);
      @(negedge i_ref_clk);
      i_reg_wr = 1'b1;
      i_reg_addr = addr;
      i_reg_page = page;
      i_reg_wdata = data;
      @(negedge i_ref_clk);
      i_reg_wr = 1'b0;
   endtask

   task automatic reg_rd(input logic [9:0] addr, input logic page, input logic [15:0] exp);
      @(negedge i_ref_clk);
      i_reg_rd = 1'b1;
      i_reg_addr = addr;
      i_reg_page = page;
      @(negedge i_ref_clk);
      i_reg_rd = 1'b0;
      chk("register read", exp, o_reg_rdata);
   endtask

   task automatic core_wr(input logic pin, input logic [15:0] data);
      @(negedge i_ref_clk);
      i_core_wr = 1'b1;
      i_core_pin = pin;
      i_core_cfg = data;
      @(negedge i_ref_clk);
      i_core_wr = 1'b0;
   endtask

   task automatic settle();
      repeat (3) @(negedge i_ref_clk);
   endtask

   // Works out the expected pin state from the configuration bits and compares it.
   task automatic check_lane(input logic p, input logic [6:0] c, input logic route, input logic dir);
      sense_mux_pkg::lane_out_t  ln;
      sense_mux_pkg::pin_mode_t  m;
      sense_mux_pkg::src_t       s;
      logic                      oe;
      logic [2:0]                ch;
      logic [9:0]                g;
      ln = p ? o_pin_b_lane : o_pin_a_lane;
      if (route && dir)
         m = sense_mux_pkg::MODE_DIG_IN;
      else if (route && c[6])
         m = sense_mux_pkg::MODE_DIG_OUT;
      else if (!route && !c[6])
         m = sense_mux_pkg::MODE_ANALOG;
      else
         m = sense_mux_pkg::MODE_PARKED;
      oe = (m == sense_mux_pkg::MODE_ANALOG) ? c[5] : (m == sense_mux_pkg::MODE_DIG_OUT);
      g = (c[4:3] == 2'b00) ? 10'h085 : (c[4:3] == 2'b01) ? 10'h0C8 : (c[4:3] == 2'b10) ? 10'h12C : 10'h215;
      chk("lane mode", 16'(m), 16'(ln.mode));
      chk("pin oe", 16'(oe), 16'(pin_oe[p]));
      chk("lane oe", 16'(oe), 16'(ln.oe));
      chk("pin out", 16'(m == sense_mux_pkg::MODE_DIG_OUT && i_flag_drive_signal[p]), 16'(pin_out[p]));
      chk("lane gain", 16'(g), 16'(ln.gain_x100));
      chk("lane gain code", 16'(c[4:3]), 16'(ln.gain_code));
      chk("lane bias", 16'(c[4]), 16'(ln.bias_shift));
      if (m == sense_mux_pkg::MODE_ANALOG && c[5])
      begin
         s = (c[2:0] == 3'h0) ? sense_mux_pkg::SRC_FIRST : (c[2:0] == 3'h1) ? sense_mux_pkg::SRC_SECOND :
             (c[2:0] == 3'h5) ? sense_mux_pkg::SRC_REF : sense_mux_pkg::SRC_OFF;
         ch = (c[2:0] == 3'h0) ? {2'b00, p} + 3'h1 : (c[2:0] == 3'h1) ? {2'b00, p} + 3'h3 : 3'h0;
         chk("lane source", 16'(s), 16'(ln.src));
         chk("lane channel", 16'(ch), 16'(ln.channel));
      end
   endtask

   initial
   begin
      #2_000_000;
      failures++;
      conclude();
   end

   initial
   begin
      repeat (16) @(negedge i_ref_clk);
      i_resetn = 1'b1;
      settle();
      check_lane(1'b0, 7'h00, 1'b0, 1'b0);
      check_lane(1'b1, 7'h00, 1'b0, 1'b0);
      reg_rd(`SM_OFS_OUT_CFG, 1'b0, 16'h0000);
      reg_rd(`SM_OFS_OUT_CFG, 1'b1, 16'h0000);
      reg_rd(`SM_OFS_FLAG_DIR, 1'b0, 16'h0000);
      reg_rd(`SM_OFS_FLAG_ROUTE, 1'b0, 16'h0000);
      for (int p = 0; p < 2; p++)
      begin
         for (int s = 0; s < 9; s++)
         begin
            cfg = (s == 8) ? 7'h18 : {2'b01, 2'(s), 3'(s)};
            if (p == 0)
               reg_wr(`SM_OFS_OUT_CFG, 1'b0, {9'h000, cfg});
            else
               core_wr(1'b1, {9'h000, cfg});
            settle();
            check_lane(1'(p), cfg, 1'b0, 1'b0);
            reg_rd(`SM_OFS_OUT_CFG, 1'(p), {9'h000, cfg});
         end
      end
      reg_wr(`SM_OFS_OUT_CFG, 1'b0, 16'hFFFF);
      reg_rd(`SM_OFS_OUT_CFG, 1'b0, 16'h007F);
      reg_wr(10'h1AB, 1'b0, 16'hFFFF);
      reg_rd(10'h1AB, 1'b0, 16'h0000);
      reg_rd(`SM_OFS_OUT_CFG, 1'b1, 16'h0018);
      @(negedge i_ref_clk);
      i_reg_wr = 1'b1;
      i_reg_addr = `SM_OFS_OUT_CFG;
      i_reg_page = 1'b0;
      i_reg_wdata = 16'h0001;
      i_core_wr = 1'b1;
      i_core_pin = 1'b0;
      i_core_cfg = 16'h0025;
      @(negedge i_ref_clk);
      i_reg_wr = 1'b0;
      i_core_wr = 1'b0;
      reg_rd(`SM_OFS_OUT_CFG, 1'b0, 16'h0025);
      // Digital function selected while routing is still off parks the pin.
      reg_wr(`SM_OFS_OUT_CFG, 1'b0, 16'h0040);
      reg_wr(`SM_OFS_OUT_CFG, 1'b1, 16'h0048);
      settle();
      check_lane(1'b0, 7'h40, 1'b0, 1'b0);
      reg_wr(`SM_OFS_FLAG_ROUTE, 1'b0, 16'hFFFF);
      reg_rd(`SM_OFS_FLAG_ROUTE, 1'b0, 16'h0C00);
      for (int v = 1; v < 4; v++)
      begin
         @(negedge i_ref_clk);
         i_flag_drive_signal = 2'(v);
         settle();
         check_lane(1'b0, 7'h40, 1'b1, 1'b0);
         check_lane(1'b1, 7'h48, 1'b1, 1'b0);
         chk("flag in", 16'h0000, {14'h0000, o_flag_in});
      end
      reg_wr(`SM_OFS_FLAG_DIR, 1'b0, 16'h0C00);
      for (int v = 1; v < 3; v++)
      begin
         @(negedge i_ref_clk);
         host_oe = 2'b11;
         host_val = 2'(v);
         settle();
         check_lane(1'b0, 7'h40, 1'b1, 1'b1);
         check_lane(1'b1, 7'h48, 1'b1, 1'b1);
         chk("flag in", 16'(v), {14'h0000, o_flag_in});
      end
      @(negedge i_ref_clk);
      i_resetn = 1'b0;
      host_oe = 2'b00;
      repeat (2) @(negedge i_ref_clk);
      i_resetn = 1'b1;
      settle();
      check_lane(1'b0, 7'h00, 1'b0, 1'b0);
      reg_rd(`SM_OFS_OUT_CFG, 1'b1, 16'h0000);
      reg_rd(`SM_OFS_FLAG_ROUTE, 1'b0, 16'h0000);
      conclude();
   end
endmodule
`default_nettype wire
